// file: rtl/sbc_defines.svh
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH
// Overview of operation
// R1: control addresses are read and written
// R2: partial-networking range holds selective-wake controls
// R3: access bit zero reads, one writes
// R4: written value shows from next frame
// R5: status range reads, or reads and clears
// R6: master sets access bit to clear status
// R7: level, identity, selective-wake status never cleared
// R8: master should clear event flags after reading
// R9: drivers enable despite set failure flags
// R10: mode field follows the entered mode
// R11: low power keeps diagnosis and fail output
// R12: stop entry leaves transceiver bits alone
// R13: sleep entry forces active transceiver wake-capable
// R14: regulator stays on, configured in normal only
// R15: low-power regulator failure switches it off
// R16: restart clears regulator bits, keeps fail output
// R17: restart sets transceiver off or wake-capable
// R18: hardware-modified control bits are hardware read/write
// R19: frame carries address, access bit, data byte
// R20: configuration applied at chip select release
// R21: writes only in init/normal, stop limited
// R22: reserved bits read zero, writes ignored
// R23: clear access clears only clearable bits

// ****************************************
// frame layout
// ****************************************
`define SBC_FRAME_BITS 6'd16
`define SBC_ADDR_BITS 6'd7
`define SBC_DATA_BITS 6'd8
`define SBC_CNT_MAX 6'h3f
`define SBC_PIN_IDLE 3'b100

// ****************************************
// address regions
// ****************************************
`define SBC_CTRL_HI 7'h1e
`define SBC_PN_LO 7'h20
`define SBC_PN_HI 7'h3f
`define SBC_STAT_LO 7'h40
`define SBC_STAT_HI 7'h7e
`define SBC_STAT_N 7'd16
`define SBC_STAT_NCLR 4'd8
`define SBC_S_FAM 4'hf

// ****************************************
// control offsets (low five address bits) and write masks
// ****************************************
`define SBC_R_MSC 5'h00
`define SBC_R_HWC0 5'h01
`define SBC_R_WDC 5'h02
`define SBC_R_CANC 5'h03
`define SBC_R_WKC0 5'h04
`define SBC_R_WKC1 5'h05
`define SBC_R_WKPU 5'h06
`define SBC_R_CANF 5'h07
`define SBC_R_TMR 5'h08
`define SBC_R_HWC1 5'h09
`define SBC_R_HWC2 5'h0a
`define SBC_R_GPIO 5'h0b
`define SBC_R_PWM 5'h0c
`define SBC_R_PWMF 5'h0d
`define SBC_R_HWC3 5'h0e
`define SBC_R_SCRL 5'h0f
`define SBC_R_SCRH 5'h10
`define SBC_R_SWKC 5'h00
`define SBC_R_SWKB 5'h01
`define SBC_M_MSC 8'hdf
`define SBC_M_HWC0 8'hf7
`define SBC_M_WDC 8'hf7
`define SBC_M_CANC 8'h07
`define SBC_M_WKC0 8'h44
`define SBC_M_WKC1 8'ha1
`define SBC_M_WKPU 8'hc3
`define SBC_M_CANF 8'h10
`define SBC_M_TMR 8'h7f
`define SBC_M_HWC1 8'hb8
`define SBC_M_HWC2 8'hfd
`define SBC_M_GPIO 8'h07
`define SBC_M_PWM 8'hff
`define SBC_M_PWMF 8'h03
`define SBC_M_HWC3 8'h07
`define SBC_M_FULL 8'hff
`define SBC_M_SWKC 8'hf1
`define SBC_M_NONE 8'h00

// ****************************************
// fields, codes and reset values
// ****************************************
`define SBC_F_MODE 7:6
`define SBC_F_REG2 4:3
`define SBC_F_CAN 2:0
`define SBC_F_FO 5
`define SBC_MODE_NORMAL 2'b00
`define SBC_MODE_SLEEP 2'b01
`define SBC_MODE_STOP 2'b10
`define SBC_MODE_RESTART 2'b11
`define SBC_REG2_OFF 2'b00
`define SBC_CAN_OFF 3'b000
`define SBC_CAN_WAKE 3'b001
`define SBC_CTRL_RST 8'h00
`define SBC_PN_RST 8'h00
`define SBC_STAT_RST 8'h00

`endif

// file: rtl/sbc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"
module sbc_pin_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire sbc_pkg::sbc_spi_in_t pin_i,
  output var sbc_pkg::sbc_spi_in_t pin_s
);
  import sbc_pkg::*;

  sbc_spi_in_t meta_r;
  sbc_spi_in_t sync_r;

  // meta_r feeds sync_r only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_r <= `SBC_PIN_IDLE;
      sync_r <= `SBC_PIN_IDLE;
    end
    else
    begin
      meta_r <= pin_i;
      sync_r <= meta_r;
    end
  end

  assign pin_s = sync_r;

endmodule
`default_nettype wire

// file: rtl/sbc_pkg.sv
package sbc_pkg;

  typedef enum logic [2:0] {
    SBC_MD_INIT = 3'b000,
    SBC_MD_NORMAL = 3'b001,
    SBC_MD_STOP = 3'b010,
    SBC_MD_SLEEP = 3'b011,
    SBC_MD_RESTART = 3'b100
  } sbc_mode_t;

  typedef struct packed {
    logic chip_select_n;
    logic sclk;
    logic mosi;
  } sbc_spi_in_t;

  typedef struct packed {
    logic vld;
    logic [3:0] idx;
    logic [7:0] bits;
  } sbc_evt_t;

  typedef struct packed {
    logic [1:0] mode_req;
    logic [1:0] secondary_regulator_enable;
    logic fail_output;
    logic [2:0] can_mode;
  } sbc_cfg_t;

endpackage

// file: rtl/sbc_spi_register_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"
module sbc_spi_register_map #(
  // identity value is arbitrary
  parameter logic [7:0] FAMILY_ID = 8'h5a
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire sbc_pkg::sbc_spi_in_t spi_in,
  output logic miso_o,
  output logic miso_oe_n,
  input wire sbc_pkg::sbc_mode_t cur_mode,
  input wire logic reg2_fail,
  input wire sbc_pkg::sbc_evt_t hw_evt,
  output sbc_pkg::sbc_cfg_t cfg_o,
  output logic mode_req_vld,
  output logic wd_trig
);
  import sbc_pkg::*;

  // ****************************************
  // pin sampling and edges
  // ****************************************
  sbc_spi_in_t pin_s;
  logic csn_q_r;
  logic sclk_q_r;

  sbc_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_i(spi_in),
    .pin_s(pin_s)
  );

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      csn_q_r <= 1'b1;
      sclk_q_r <= 1'b0;
    end
    else
    begin
      csn_q_r <= pin_s.chip_select_n;
      sclk_q_r <= pin_s.sclk;
    end
  end

  wire in_frame = ~pin_s.chip_select_n;
  wire frame_start = csn_q_r & in_frame;
  wire frame_end = ~csn_q_r & pin_s.chip_select_n;
  wire spi_rise = in_frame & ~sclk_q_r & pin_s.sclk;
  wire spi_fall = in_frame & sclk_q_r & ~pin_s.sclk;

  // ****************************************
  // shift engine
  // ****************************************
  logic [5:0] bit_cnt_r;
  logic [15:0] sh_r;
  logic [7:0] rd_r;
  logic [7:0] sif_r;
  logic miso_r;
  logic [7:0] rd_w;
  logic [7:0] sif_w;
  logic tx_bit;

  // lsb first: after seven bits the address sits in sh_r[15:9]
  wire [6:0] rd_addr = sh_r[15:9];
  wire rd_cap = spi_rise & (bit_cnt_r == `SBC_ADDR_BITS);

  always_ff @(posedge ref_clk)
  begin
    if (rst || frame_start)
      bit_cnt_r <= 6'h00;
    else if (spi_rise && bit_cnt_r != `SBC_CNT_MAX)
      bit_cnt_r <= bit_cnt_r + 6'd1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sh_r <= 16'h0000;
    else if (spi_rise)
      sh_r <= {pin_s.mosi, sh_r[15:1]};
  end

  // R4: old contents
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rd_r <= 8'h00;
    else if (rd_cap)
      rd_r <= rd_w;
  end

  always_comb
  begin
    tx_bit = 1'b0;
    if (bit_cnt_r < `SBC_DATA_BITS)
      tx_bit = sif_r[bit_cnt_r[2:0]];
    else if (bit_cnt_r < `SBC_FRAME_BITS)
      tx_bit = rd_r[bit_cnt_r[2:0]];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sif_r <= 8'h00;
      miso_r <= 1'b0;
    end
    else if (frame_start)
    begin
      sif_r <= sif_w;
      miso_r <= sif_w[0];
    end
    else if (spi_fall)
      miso_r <= tx_bit;
    else if (frame_end)
      miso_r <= 1'b0;
  end

  assign miso_o = miso_r;
  // driven only while chip select is low
  assign miso_oe_n = pin_s.chip_select_n;

  // ****************************************
  // frame decode
  // ****************************************
  // R19: frame fields
  wire [6:0] f_addr = sh_r[6:0];
  wire f_acc = sh_r[7];
  wire [7:0] f_data = sh_r[15:8];
  wire [4:0] cidx = f_addr[4:0];
  wire [6:0] sidx = f_addr - `SBC_STAT_LO;
  wire [3:0] scidx = sidx[3:0];

  wire md_norm = cur_mode == SBC_MD_NORMAL;
  wire md_stop = cur_mode == SBC_MD_STOP;
  wire md_sleep = cur_mode == SBC_MD_SLEEP;
  wire md_rst = cur_mode == SBC_MD_RESTART;
  wire md_cfg = md_norm | (cur_mode == SBC_MD_INIT);

  // R20: commit at release, whole frames only
  wire fr_ok = frame_end & (bit_cnt_r == `SBC_FRAME_BITS) & ~md_rst;
  // R3: access bit selects write
  wire fr_wr = fr_ok & f_acc;
  // R1: control range
  wire in_ctrl = f_addr <= `SBC_CTRL_HI;
  // R2: partial-networking range
  wire in_pn = (f_addr >= `SBC_PN_LO) && (f_addr <= `SBC_PN_HI);
  // R5: status range
  wire in_stat = (f_addr >= `SBC_STAT_LO) && (f_addr <= `SBC_STAT_HI);
  wire s_hit = sidx < `SBC_STAT_N;

  // R21: stop allows only normal request and watchdog
  wire stop_ok = md_stop & (((cidx == `SBC_R_MSC) & (f_data[`SBC_F_MODE] == `SBC_MODE_NORMAL))
                 | (cidx == `SBC_R_WDC));
  wire ctrl_we = fr_wr & in_ctrl & (md_cfg | stop_ok);
  wire pn_we = fr_wr & in_pn & md_cfg;
  // R7: upper status entries never cleared
  wire stat_clr = fr_wr & in_stat & s_hit & (scidx < `SBC_STAT_NCLR);

  // R22: reserved positions masked
  function automatic logic [7:0] ctrl_mask(input logic [4:0] i);
    case (i)
      `SBC_R_MSC: ctrl_mask = `SBC_M_MSC;
      `SBC_R_HWC0: ctrl_mask = `SBC_M_HWC0;
      `SBC_R_WDC: ctrl_mask = `SBC_M_WDC;
      `SBC_R_CANC: ctrl_mask = `SBC_M_CANC;
      `SBC_R_WKC0: ctrl_mask = `SBC_M_WKC0;
      `SBC_R_WKC1: ctrl_mask = `SBC_M_WKC1;
      `SBC_R_WKPU: ctrl_mask = `SBC_M_WKPU;
      `SBC_R_CANF: ctrl_mask = `SBC_M_CANF;
      `SBC_R_TMR: ctrl_mask = `SBC_M_TMR;
      `SBC_R_HWC1: ctrl_mask = `SBC_M_HWC1;
      `SBC_R_HWC2: ctrl_mask = `SBC_M_HWC2;
      `SBC_R_GPIO: ctrl_mask = `SBC_M_GPIO;
      `SBC_R_PWM: ctrl_mask = `SBC_M_PWM;
      `SBC_R_PWMF: ctrl_mask = `SBC_M_PWMF;
      `SBC_R_HWC3: ctrl_mask = `SBC_M_HWC3;
      `SBC_R_SCRL: ctrl_mask = `SBC_M_FULL;
      `SBC_R_SCRH: ctrl_mask = `SBC_M_FULL;
      default: ctrl_mask = `SBC_M_NONE;
    endcase
  endfunction

  function automatic logic [7:0] pn_mask(input logic [4:0] i);
    pn_mask = (i == `SBC_R_SWKC) ? `SBC_M_SWKC : `SBC_M_FULL;
  endfunction

  function automatic logic [1:0] mode_enc(input sbc_mode_t m);
    case (m)
      SBC_MD_SLEEP: mode_enc = `SBC_MODE_SLEEP;
      SBC_MD_STOP: mode_enc = `SBC_MODE_STOP;
      SBC_MD_RESTART: mode_enc = `SBC_MODE_RESTART;
      default: mode_enc = `SBC_MODE_NORMAL;
    endcase
  endfunction

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] ctrl_r [0:31];
  logic [7:0] pn_r [0:31];
  logic [7:0] stat_r [0:15];
  sbc_mode_t mode_q_r;
  logic [7:0] msc_hw;
  logic [7:0] msc_wd;
  logic [7:0] msc_nxt;
  logic [7:0] can_hw;
  logic [7:0] can_nxt;

  wire [7:0] wdat = f_data & ctrl_mask(cidx);
  wire [7:0] msc_cur = ctrl_r[`SBC_R_MSC];
  wire [7:0] can_cur = ctrl_r[`SBC_R_CANC];
  wire mode_chg = cur_mode != mode_q_r;
  wire wr_msc = ctrl_we & (cidx == `SBC_R_MSC);
  wire can_low = (can_cur[`SBC_F_CAN] == `SBC_CAN_OFF)
                 | (can_cur[`SBC_F_CAN] == `SBC_CAN_WAKE);
  // R15: regulator failure in low power, no wake raised
  wire reg2_cut = (md_stop | md_sleep) & reg2_fail
                  & (msc_cur[`SBC_F_REG2] != `SBC_REG2_OFF);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mode_q_r <= SBC_MD_INIT;
    else
      mode_q_r <= cur_mode;
  end

  // R18: mode, regulator and transceiver fields are hardware-modified
  always_comb
  begin
    msc_hw = msc_cur;
    // R10: mode field follows
    msc_hw[`SBC_F_MODE] = mode_enc(cur_mode);
    // R16: restart clears regulator bits
    if (md_rst)
      msc_hw[`SBC_F_REG2] = `SBC_REG2_OFF;
    // R14: in stop only the mode field moves, regulator kept
    if (md_stop)
      msc_wd = (f_data & `SBC_M_MSC & {2'b11, 6'h00}) | (msc_cur & {2'b00, 6'h3f});
    else if (md_norm)
      msc_wd = wdat;
    else
      msc_wd = (wdat & {3'b111, 2'b00, 3'b111}) | (msc_cur & {3'b000, 2'b11, 3'b000});
    if (mode_chg)
      msc_nxt = msc_hw;
    else if (reg2_cut)
      msc_nxt = {msc_cur[7:5], `SBC_REG2_OFF, msc_cur[2:0]};
    else if (wr_msc)
      msc_nxt = msc_wd;
    else
      msc_nxt = msc_cur;
  end

  always_comb
  begin
    can_hw = can_cur;
    // R12: stop keeps, R13 and R17 force wake-capable
    if ((md_sleep | md_rst) && !can_low)
      can_hw[`SBC_F_CAN] = `SBC_CAN_WAKE;
    if (mode_chg)
      can_nxt = can_hw;
    else if (ctrl_we && cidx == `SBC_R_CANC)
      can_nxt = wdat;
    else
      can_nxt = can_cur;
  end

  // R11: fail output and diagnosis bits untouched by mode changes
  for (genvar g = 0; g < 32; g++)
  begin : g_ctrl
    logic [7:0] nxt;
    always_comb
    begin
      if (5'(g) == `SBC_R_MSC)
        nxt = msc_nxt;
      else if (5'(g) == `SBC_R_CANC)
        nxt = can_nxt;
      else if (ctrl_we && cidx == 5'(g))
        nxt = wdat;
      else
        nxt = ctrl_r[g];
    end
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        ctrl_r[g] <= `SBC_CTRL_RST;
      else
        ctrl_r[g] <= nxt;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 32; i++)
        pn_r[i] <= `SBC_PN_RST;
    end
    else if (pn_we)
      pn_r[cidx] <= f_data & pn_mask(cidx);
  end

  // ****************************************
  // status registers
  // ****************************************
  for (genvar s = 0; s < 16; s++)
  begin : g_stat
    wire s_set = hw_evt.vld && (hw_evt.idx == 4'(s));
    wire s_clr = stat_clr && (scidx == 4'(s));
    if (s < 8)
    begin : g_clr
      assign sif_w[s] = |stat_r[s];
      // R23: set wins over clear
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          stat_r[s] <= `SBC_STAT_RST;
        else
          stat_r[s] <= (stat_r[s] & ~{8{s_clr}}) | (s_set ? hw_evt.bits : 8'h00);
      end
    end
    else
    begin : g_live
      // R7: live values, no clear path
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          stat_r[s] <= `SBC_STAT_RST;
        else if (s_set)
          stat_r[s] <= hw_evt.bits;
      end
    end
  end

  // ****************************************
  // read data and outputs
  // ****************************************
  wire [6:0] rsidx = rd_addr - `SBC_STAT_LO;

  always_comb
  begin
    rd_w = 8'h00;
    if (rd_addr <= `SBC_CTRL_HI)
      rd_w = ctrl_r[rd_addr[4:0]] & ctrl_mask(rd_addr[4:0]);
    else if (rd_addr >= `SBC_PN_LO && rd_addr <= `SBC_PN_HI)
      rd_w = pn_r[rd_addr[4:0]];
    else if (rd_addr <= `SBC_STAT_HI && rsidx < `SBC_STAT_N)
      rd_w = (rsidx[3:0] == `SBC_S_FAM) ? FAMILY_ID : stat_r[rsidx[3:0]];
  end

  // R9: enables follow writes regardless of failure flags
  assign cfg_o = {msc_cur[`SBC_F_MODE], msc_cur[`SBC_F_REG2],
                  ctrl_r[`SBC_R_HWC0][`SBC_F_FO], can_cur[`SBC_F_CAN]};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_req_vld <= 1'b0;
      wd_trig <= 1'b0;
    end
    else
    begin
      mode_req_vld <= wr_msc;
      wd_trig <= ctrl_we & (cidx == `SBC_R_WDC);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_CTRL_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // R1
    ctrl_we && cidx == `SBC_R_WDC |=> ctrl_r[`SBC_R_WDC] == $past(wdat) && wd_trig)
    else $error("control write not stored");
  AST_PN_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // R2
    pn_we && cidx == `SBC_R_SWKB |=> pn_r[`SBC_R_SWKB] == $past(f_data))
    else $error("selective wake write lost");
  AST_READ_ONLY: assert property (@(posedge ref_clk) disable iff (rst) // R3
    fr_ok && !f_acc |=> ctrl_r[`SBC_R_HWC0] == $past(ctrl_r[`SBC_R_HWC0]))
    else $error("read frame changed a register");
  AST_OLD_DATA: assert property (@(posedge ref_clk) disable iff (rst) // R4
    fr_wr && f_addr == {2'b00, `SBC_R_WDC} |-> rd_r == ctrl_r[`SBC_R_WDC])
    else $error("frame returned new data");
  AST_STAT_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // R23
    stat_clr && scidx == 4'h2 && !(hw_evt.vld && hw_evt.idx == 4'h2)
    |=> stat_r[2] == 8'h00 ##1 (!sif_w[2] || $past(hw_evt.vld)))
    else $error("status clear failed");
  AST_NO_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // R7
    fr_wr && f_addr == 7'h48 && !hw_evt.vld |=> $stable(stat_r[8]))
    else $error("fixed status cleared");
  AST_MODE_FIELD: assert property (@(posedge ref_clk) disable iff (rst) // R10
    mode_chg |=> msc_cur[`SBC_F_MODE] == mode_enc($past(cur_mode)))
    else $error("mode field not updated");
  AST_STOP_CAN: assert property (@(posedge ref_clk) disable iff (rst) // R12
    mode_chg && md_stop |=> $stable(can_cur))
    else $error("stop entry changed transceiver bits");
  AST_SLEEP_CAN: assert property (@(posedge ref_clk) disable iff (rst) // R13
    mode_chg && md_sleep |=> can_low)
    else $error("sleep entry left transceiver active");
  AST_RESTART: assert property (@(posedge ref_clk) disable iff (rst) // R16
    mode_chg && md_rst |=> msc_cur[`SBC_F_REG2] == `SBC_REG2_OFF && $stable(cfg_o.fail_output))
    else $error("restart entry wrong");
  AST_REG2_CUT: assert property (@(posedge ref_clk) disable iff (rst) // R15
    reg2_cut && !mode_chg |=> cfg_o.secondary_regulator_enable == `SBC_REG2_OFF)
    else $error("regulator not switched off");
  AST_APPLY_END: assert property (@(posedge ref_clk) disable iff (rst) // R20
    !frame_end |=> $stable(ctrl_r[`SBC_R_PWMF]))
    else $error("configuration changed inside frame");
  AST_STOP_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // R21
    fr_wr && md_stop && cidx == `SBC_R_HWC0 |=> $stable(ctrl_r[`SBC_R_HWC0]))
    else $error("write accepted in stop");

endmodule
`default_nettype wire

// file: sim/sbc_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_master (
  output var sbc_pkg::sbc_spi_in_t pins,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  import sbc_pkg::*;

  // half of the 125 ns link clock period
  localparam realtime HALF = 62.5;
  int oe_bad = 0;

  // clock rests low between frames so chip select edges see it low
  initial pins = '{chip_select_n: 1'b1, sclk: 1'b0, mosi: 1'b1};

  // lsb-first frame, access bit and clear chosen by caller
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    pins.chip_select_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      pins.mosi = tx[i];
      #(HALF);
      pins.sclk = 1'b1;
      rx[i] = miso_o;
      if (miso_oe_n !== 1'b0)
        oe_bad++;
      #(HALF);
      pins.sclk = 1'b0;
    end
    #(HALF);
    pins.chip_select_n = 1'b1;
    // a released data line must not look like a held bit
    pins.mosi = ~pins.mosi;
    #(HALF * 2);
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sbc_pkg::*;

  // identity value is arbitrary
  localparam logic [7:0] FAM = 8'h3c;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  sbc_spi_in_t pins;
  sbc_mode_t cur_mode = SBC_MD_NORMAL;
  logic reg2_fail = 1'b0;
  sbc_evt_t hw_evt = '0;
  sbc_cfg_t cfg_o;
  logic miso_o;
  logic miso_oe_n;
  logic mode_req_vld;
  logic wd_trig;
  logic [15:0] rx;
  logic [23:0] rows [19];
  int n_mismatch = 0;
  int n_checks = 0;
  int n_wd = 0;
  int n_mreq = 0;

  always #5 ref_clk = ~ref_clk;

  sbc_spi_register_map #(.FAMILY_ID(FAM)) dut (
    .ref_clk(ref_clk), .rst(rst), .spi_in(pins), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .cur_mode(cur_mode), .reg2_fail(reg2_fail),
    .hw_evt(hw_evt), .cfg_o(cfg_o), .mode_req_vld(mode_req_vld), .wd_trig(wd_trig)
  );

  sbc_spi_master master (.pins(pins), .miso_o(miso_o), .miso_oe_n(miso_oe_n));

  always @(posedge ref_clk)
  begin
    if (wd_trig === 1'b1)
      n_wd++;
    if (mode_req_vld === 1'b1)
      n_mreq++;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // ctl holds access bit and address; exp is the byte returned in this frame
  task automatic frame(input logic [7:0] ctl, input logic [7:0] data, input logic [7:0] exp);
    master.xfer({data, ctl}, 16, rx);
    chk_byte(rx[15:8], exp);
  endtask

  task automatic evt(input logic [3:0] idx, input logic [7:0] bits);
    @(negedge ref_clk);
    hw_evt = '{vld: 1'b1, idx: idx, bits: bits};
    @(negedge ref_clk);
    hw_evt = '0;
  endtask

  task automatic set_mode(input sbc_mode_t m);
    @(negedge ref_clk);
    cur_mode = m;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // run is about 85 us; nearly five times that means a hang
  initial
  begin
    #400000;
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    finish_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rows = '{24'h83ff00, 24'h030007, 24'h81ff00, 24'h0100f7, 24'h801800, 24'h000018,
             24'h90a500, 24'h1000a5, 24'h8dff00, 24'h0d0003, 24'ha0ff00, 24'h2000f1,
             24'ha13c00, 24'h21003c, 24'h9fff00, 24'h1f0000, {16'hcfff, FAM},
             {16'h4f00, FAM}, 24'hd0ff00};
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_byte(cfg_o, 8'h00);
    chk_byte({7'h00, miso_oe_n}, 8'h01);
    foreach (rows[i])
    begin
      frame(rows[i][23:16], rows[i][15:8], rows[i][7:0]);
      chk_byte(rx[7:0], 8'h00);
    end
    chk_byte(cfg_o, 8'h3f);
    chk_cnt(n_mreq, 1);
    chk_cnt(master.oe_bad, 0);
    // a frame one bit short must change nothing
    master.xfer({8'h55, 8'h8f}, 15, rx);
    frame(8'h0f, 8'h00, 8'h00);
    // sticky entries, clear only the addressed one
    evt(4'h2, 8'h81);
    evt(4'h3, 8'h10);
    frame(8'h83, 8'h05, 8'h07);
    frame(8'h42, 8'h00, 8'h81);
    chk_byte(rx[7:0], 8'h0c);
    frame(8'hc2, 8'h00, 8'h81);
    frame(8'h42, 8'h00, 8'h00);
    chk_byte(rx[7:0], 8'h08);
    frame(8'h43, 8'h00, 8'h10);
    frame(8'h03, 8'h00, 8'h05);
    evt(4'h8, 8'h33);
    frame(8'hc8, 8'h00, 8'h33);
    frame(8'h48, 8'h00, 8'h33);
    // mode transitions
    set_mode(SBC_MD_STOP);
    frame(8'h00, 8'h00, 8'h98);
    frame(8'h03, 8'h00, 8'h05);
    frame(8'h81, 8'h00, 8'hf7);
    frame(8'h01, 8'h00, 8'hf7);
    frame(8'h82, 8'h12, 8'h00);
    chk_cnt(n_wd, 1);
    set_mode(SBC_MD_SLEEP);
    frame(8'h00, 8'h00, 8'h58);
    frame(8'h03, 8'h00, 8'h01);
    chk_byte({7'h00, cfg_o.fail_output}, 8'h01);
    set_mode(SBC_MD_RESTART);
    chk_byte({7'h00, cfg_o.fail_output}, 8'h01);
    chk_byte({6'h00, cfg_o.secondary_regulator_enable}, 8'h00);
    chk_byte({5'h00, cfg_o.can_mode}, 8'h01);
    set_mode(SBC_MD_NORMAL);
    frame(8'h00, 8'h00, 8'h00);
    frame(8'h80, 8'h18, 8'h00);
    chk_cnt(n_mreq, 2);
    set_mode(SBC_MD_STOP);
    reg2_fail = 1'b1;
    repeat (3) @(negedge ref_clk);
    frame(8'h00, 8'h00, 8'h80);
    reg2_fail = 1'b0;
    finish_test();
  end
endmodule
`default_nettype wire
